// [cthi_params.svh]
// cthi_params.svh: offsets, field positions, widths, threshold and counts for the
// transmit history and interrupt grouping block. Definitions only.
`ifndef CTHI_PARAMS_SVH
`define CTHI_PARAMS_SVH

`define CTHI_DEPTH 8
`define CTHI_PTR_W 3
`define CTHI_CNT_W 4
`define CTHI_LABEL_W 8
`define CTHI_THRESHOLD 4'h6

`define CTHI_OFS_GLOBAL_CONTROL 8'h00
`define CTHI_OFS_HISTORY_CONTROL 8'h04
`define CTHI_OFS_HISTORY_STATUS 8'h08
`define CTHI_OFS_HISTORY_READ_WINDOW 8'h0c
`define CTHI_OFS_GLOBAL_TX_IRQ_STATUS 8'h10

`define CTHI_GC_OVF_IE_BIT 0
`define CTHI_HC_ENABLE_BIT 0
`define CTHI_HC_MODE_BIT 1
`define CTHI_HC_IE_BIT 2
`define CTHI_HC_LINK_LSB 4
`define CTHI_HS_EMPTY_BIT 0
`define CTHI_HS_FULL_BIT 1
`define CTHI_HS_OVF_BIT 2
`define CTHI_HS_IRQ_BIT 3
`define CTHI_HS_CNT_LSB 8
`define CTHI_RW_KIND_LSB 0
`define CTHI_RW_INDEX_LSB 2
`define CTHI_RW_LABEL_LSB 8

`define CTHI_KIND_BUFFER 2'h1
`define CTHI_KIND_FIFO 2'h2

`endif

// [cthi_pkg.sv]
// cthi_pkg: types shared by the transmit history block and its users.
// assumes cthi_params.svh is on the include path.
`include "cthi_params.svh"
package cthi_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cthi_bus_req_t;

    // one transmit-complete event from the buffer or fifo logic
    typedef struct packed {
        logic valid;
        logic ok;
        logic from_fifo;
        logic [1:0] buf_idx;
        logic store_en;
        logic [`CTHI_LABEL_W-1:0] label;
    } cthi_tx_evt_t;

    typedef struct packed {
        logic [1:0] record_source_kind;
        logic [1:0] record_source_index;
        logic [`CTHI_LABEL_W-1:0] label;
    } cthi_record_t;

    typedef struct packed {
        logic history_overflow_irq_enable;
        logic history_enable;
        logic history_irq_mode;
        logic history_irq_enable;
        logic [1:0] fifo_link_buffer_select;
        logic history_irq_request;
        logic overflow;
        cthi_record_t [`CTHI_DEPTH-1:0] mem;
        logic [`CTHI_PTR_W-1:0] wp;
        logic [`CTHI_PTR_W-1:0] rp;
        logic [`CTHI_CNT_W-1:0] cnt;
        logic can_rx_prev;
        logic [31:0] rdata;
        logic irq_global_rx_fifo;
        logic irq_global_error;
        logic irq_chan_tx;
        logic irq_chan_fifo_rx;
        logic irq_chan_error;
        logic irq_chan_wakeup;
    } cthi_state_t;

endpackage

// [cthi_top.sv]
// cthi_top: one channel's transmit history buffer plus the grouping of the
// module's interrupt sources onto six registered interrupt outputs.
// assumes all inputs synchronous to mclk; event inputs are one-cycle pulses,
// request inputs are levels held by the logic that owns their flags.
//
// Overview of operation
// [R1] one history buffer per channel holding up to eight records
// [R2] records written only for error-free transmissions, never for failed ones
// [R3] source kind 01 for dedicated buffer, 10 for fifo
// [R4] dedicated records carry buffer index 0 to 3
// [R5] fifo records carry the buffer number the fifo is linked to
// [R6] each record carries the label supplied with its message
// [R7] per-message store enable decides whether a record is made
// [R8] threshold mode raises the history request at six records held
// [R9] other mode raises the history request on every stored record
// [R10] disabling history keeps a pending request until software clears it
// [R11] history irq enable gates the request into the channel transmit irq
// [R12] history overflow raises the global error irq when reporting enabled
// [R13] one global control bit enables overflow reporting module wide
// [R14] channel transmit irq merges four sources, visible in global status
// [R15] six interrupt outputs are provided
// [R16] global receive fifo irq follows any receive fifo request
// [R17] channel fifo receive irq follows any tx/rx fifo receive request
// [R18] wakeup irq on a falling edge of the bus receive signal
// [R19] software confirms all transmit request flags cleared before leaving service
// [R20] records read oldest first; advancing frees one; empty/full follow count
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cthi_top
    import cthi_pkg::*;
#(
    parameter int RX_FIFOS = 2,
    parameter int TXRX_FIFOS = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire cthi_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // transmit completion
    input wire cthi_tx_evt_t tx_evt,
    // other interrupt request levels
    input wire logic tx_complete_req,
    input wire logic tx_abort_req,
    input wire logic fifo_tx_req,
    input wire logic [RX_FIFOS-1:0] rx_fifo_req,
    input wire logic [TXRX_FIFOS-1:0] txrx_fifo_rx_req,
    input wire logic dlc_error_req,
    input wire logic fifo_msg_lost_req,
    input wire logic chan_error_req,
    // bus receive line
    input wire logic can_rx,
    // interrupt outputs
    output logic irq_global_rx_fifo,
    output logic irq_global_error,
    output logic irq_chan_tx,
    output logic irq_chan_fifo_rx,
    output logic irq_chan_error,
    output logic irq_chan_wakeup
);

    cthi_state_t st_reg;
    cthi_state_t st_next;
    logic full;
    logic pop;
    logic want_store;
    logic do_store;
    logic hist_src;
    logic [3:0] tx_sources;

    function automatic logic hit(input cthi_bus_req_t r, input logic [7:0] ofs);
        hit = r.addr == ofs;
    endfunction

    assign full = st_reg.cnt == `CTHI_CNT_W'(`CTHI_DEPTH); // R1
    assign pop = bus_req.wr && hit(bus_req, `CTHI_OFS_HISTORY_READ_WINDOW) && st_reg.cnt != 4'h0; // R20
    assign want_store = tx_evt.valid && tx_evt.ok && tx_evt.store_en && st_reg.history_enable; // R2 R7
    assign do_store = want_store && (!full || pop);
    assign hist_src = st_reg.history_irq_request && st_reg.history_irq_enable; // R11
    assign tx_sources = {st_reg.history_irq_request, fifo_tx_req, tx_abort_req, tx_complete_req}; // R14

    always_comb begin
        st_next = st_reg;
        st_next.can_rx_prev = can_rx;
        // register writes
        if (bus_req.wr && hit(bus_req, `CTHI_OFS_GLOBAL_CONTROL)) begin
            st_next.history_overflow_irq_enable = bus_req.wdata[`CTHI_GC_OVF_IE_BIT]; // R13
        end
        if (bus_req.wr && hit(bus_req, `CTHI_OFS_HISTORY_CONTROL)) begin
            st_next.history_enable = bus_req.wdata[`CTHI_HC_ENABLE_BIT];
            st_next.history_irq_mode = bus_req.wdata[`CTHI_HC_MODE_BIT];
            st_next.history_irq_enable = bus_req.wdata[`CTHI_HC_IE_BIT];
            st_next.fifo_link_buffer_select = bus_req.wdata[`CTHI_HC_LINK_LSB +: 2];
        end
        // flags clear on a written zero; a same-cycle set below still wins
        if (bus_req.wr && hit(bus_req, `CTHI_OFS_HISTORY_STATUS)) begin
            if (!bus_req.wdata[`CTHI_HS_OVF_BIT]) begin
                st_next.overflow = 1'b0;
            end
            if (!bus_req.wdata[`CTHI_HS_IRQ_BIT]) begin
                st_next.history_irq_request = 1'b0;
            end
        end
        // buffer contents and pointers
        if (pop) begin
            st_next.rp = st_reg.rp + 3'h1; // R20
        end
        if (do_store) begin
            st_next.mem[st_reg.wp].record_source_kind = tx_evt.from_fifo ? `CTHI_KIND_FIFO : `CTHI_KIND_BUFFER; // R3
            st_next.mem[st_reg.wp].record_source_index =
                tx_evt.from_fifo ? st_reg.fifo_link_buffer_select : tx_evt.buf_idx; // R4 R5
            st_next.mem[st_reg.wp].label = tx_evt.label; // R6
            st_next.wp = st_reg.wp + 3'h1;
        end
        if (do_store && !pop) begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end else if (!do_store && pop) begin
            st_next.cnt = st_reg.cnt - 4'h1;
        end
        if (want_store && !do_store) begin
            st_next.overflow = 1'b1; // R12
        end
        if (do_store && (st_reg.history_irq_mode || st_next.cnt == `CTHI_THRESHOLD)) begin
            st_next.history_irq_request = 1'b1; // R8 R9
        end
        // disabling empties the buffer but leaves the request flag alone
        if (!st_next.history_enable) begin
            st_next.wp = 3'h0; // R10
            st_next.rp = 3'h0;
            st_next.cnt = 4'h0;
        end
        // read data, valid the cycle after the strobe only
        st_next.rdata = 32'h0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `CTHI_OFS_GLOBAL_CONTROL: begin
                    st_next.rdata[`CTHI_GC_OVF_IE_BIT] = st_reg.history_overflow_irq_enable;
                end
                `CTHI_OFS_HISTORY_CONTROL: begin
                    st_next.rdata[`CTHI_HC_ENABLE_BIT] = st_reg.history_enable;
                    st_next.rdata[`CTHI_HC_MODE_BIT] = st_reg.history_irq_mode;
                    st_next.rdata[`CTHI_HC_IE_BIT] = st_reg.history_irq_enable;
                    st_next.rdata[`CTHI_HC_LINK_LSB +: 2] = st_reg.fifo_link_buffer_select;
                end
                `CTHI_OFS_HISTORY_STATUS: begin
                    st_next.rdata[`CTHI_HS_EMPTY_BIT] = st_reg.cnt == 4'h0; // R20
                    st_next.rdata[`CTHI_HS_FULL_BIT] = full;
                    st_next.rdata[`CTHI_HS_OVF_BIT] = st_reg.overflow;
                    st_next.rdata[`CTHI_HS_IRQ_BIT] = st_reg.history_irq_request;
                    st_next.rdata[`CTHI_HS_CNT_LSB +: 4] = st_reg.cnt;
                end
                `CTHI_OFS_HISTORY_READ_WINDOW: begin
                    // an empty buffer reads as zero rather than stale data
                    if (st_reg.cnt != 4'h0) begin
                        st_next.rdata[`CTHI_RW_KIND_LSB +: 2] = st_reg.mem[st_reg.rp].record_source_kind;
                        st_next.rdata[`CTHI_RW_INDEX_LSB +: 2] = st_reg.mem[st_reg.rp].record_source_index;
                        st_next.rdata[`CTHI_RW_LABEL_LSB +: `CTHI_LABEL_W] = st_reg.mem[st_reg.rp].label;
                    end
                end
                `CTHI_OFS_GLOBAL_TX_IRQ_STATUS: begin
                    st_next.rdata[3:0] = tx_sources; // R14
                end
                default: begin
                    st_next.rdata = 32'h0;
                end
            endcase
        end
        // interrupt outputs, one register stage after their sources
        st_next.irq_global_rx_fifo = |rx_fifo_req; // R15 R16
        st_next.irq_global_error = dlc_error_req || fifo_msg_lost_req
            || (st_reg.overflow && st_reg.history_overflow_irq_enable); // R12 R13
        st_next.irq_chan_tx = tx_complete_req || tx_abort_req || fifo_tx_req || hist_src; // R11 R14
        st_next.irq_chan_fifo_rx = |txrx_fifo_rx_req; // R17
        st_next.irq_chan_error = chan_error_req;
        st_next.irq_chan_wakeup = st_reg.can_rx_prev && !can_rx; // R18
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.can_rx_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata = st_reg.rdata;
    assign irq_global_rx_fifo = st_reg.irq_global_rx_fifo;
    assign irq_global_error = st_reg.irq_global_error;
    assign irq_chan_tx = st_reg.irq_chan_tx;
    assign irq_chan_fifo_rx = st_reg.irq_chan_fifo_rx;
    assign irq_chan_error = st_reg.irq_chan_error;
    assign irq_chan_wakeup = st_reg.irq_chan_wakeup;

    // checks
    logic clr_irq_wr;
    assign clr_irq_wr = bus_req.wr && hit(bus_req, `CTHI_OFS_HISTORY_STATUS) && !bus_req.wdata[`CTHI_HS_IRQ_BIT];

    sequence s_store_only;
        do_store && !pop && st_next.history_enable;
    endsequence

    sequence s_rx_fall;
        can_rx ##1 !can_rx;
    endsequence

    property p_depth;
        @(posedge mclk) disable iff (!rst_b) st_reg.cnt <= 4'h8;
    endproperty
    a_depth: assert property (p_depth) else $error("history count above eight"); // R1

    property p_no_record_on_fail;
        @(posedge mclk) disable iff (!rst_b)
            (tx_evt.valid && (!tx_evt.ok || !tx_evt.store_en) && !pop && st_next.history_enable)
                |=> $stable(st_reg.cnt);
    endproperty
    a_no_record_on_fail: assert property (p_no_record_on_fail) else $error("record made without success"); // R2 R7

    property p_store_counts;
        @(posedge mclk) disable iff (!rst_b)
            s_store_only |=> st_reg.cnt == $past(st_reg.cnt) + 4'h1;
    endproperty
    a_store_counts: assert property (p_store_counts) else $error("store did not count"); // R2

    property p_buffer_record;
        @(posedge mclk) disable iff (!rst_b)
            (do_store && !tx_evt.from_fifo) |=>
                st_reg.mem[$past(st_reg.wp)].record_source_kind == 2'h1
                && st_reg.mem[$past(st_reg.wp)].record_source_index == $past(tx_evt.buf_idx)
                && st_reg.mem[$past(st_reg.wp)].label == $past(tx_evt.label);
    endproperty
    a_buffer_record: assert property (p_buffer_record) else $error("bad buffer record"); // R3 R4 R6

    property p_fifo_record;
        @(posedge mclk) disable iff (!rst_b)
            (do_store && tx_evt.from_fifo) |=>
                st_reg.mem[$past(st_reg.wp)].record_source_kind == 2'h2
                && st_reg.mem[$past(st_reg.wp)].record_source_index == $past(st_reg.fifo_link_buffer_select);
    endproperty
    a_fifo_record: assert property (p_fifo_record) else $error("bad fifo record"); // R3 R5

    property p_threshold;
        @(posedge mclk) disable iff (!rst_b)
            (s_store_only ##0 (!st_reg.history_irq_mode && st_reg.cnt == 4'h5)) |=> st_reg.history_irq_request;
    endproperty
    a_threshold: assert property (p_threshold) else $error("no request at six records"); // R8

    property p_each;
        @(posedge mclk) disable iff (!rst_b)
            (do_store && st_reg.history_irq_mode) |=> st_reg.history_irq_request;
    endproperty
    a_each: assert property (p_each) else $error("no request on store"); // R9

    property p_sticky;
        @(posedge mclk) disable iff (!rst_b)
            (st_reg.history_irq_request && !clr_irq_wr) |=> st_reg.history_irq_request;
    endproperty
    a_sticky: assert property (p_sticky) else $error("request lost without clear"); // R10

    property p_chan_tx;
        @(posedge mclk) disable iff (!rst_b)
            1'b1 |=> irq_chan_tx == ($past(tx_complete_req) || $past(tx_abort_req) || $past(fifo_tx_req)
                || ($past(st_reg.history_irq_request) && $past(st_reg.history_irq_enable)));
    endproperty
    a_chan_tx: assert property (p_chan_tx) else $error("channel tx irq mismatch"); // R11 R14

    property p_overflow_report;
        @(posedge mclk) disable iff (!rst_b)
            (want_store && full && !pop && st_reg.history_overflow_irq_enable
                && !bus_req.wr) |=> ##1 irq_global_error;
    endproperty
    a_overflow_report: assert property (p_overflow_report) else $error("overflow not reported"); // R12 R13

    property p_rx_fifo;
        @(posedge mclk) disable iff (!rst_b)
            (|rx_fifo_req) |=> irq_global_rx_fifo;
    endproperty
    a_rx_fifo: assert property (p_rx_fifo) else $error("rx fifo irq missing"); // R16

    property p_fifo_rx;
        @(posedge mclk) disable iff (!rst_b)
            (|txrx_fifo_rx_req) |=> irq_chan_fifo_rx;
    endproperty
    a_fifo_rx: assert property (p_fifo_rx) else $error("fifo receive irq missing"); // R17

    property p_wakeup;
        @(posedge mclk) disable iff (!rst_b)
            s_rx_fall |=> irq_chan_wakeup;
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wakeup irq missing"); // R18

endmodule

// [cthi_can_node.sv]
// cthi_can_node: far side of the history block, i.e. the transmit logic that
// reports finished frames and a bus node that drives the receive line.
// assumes its tasks are called from one process synchronous to mclk.
`timescale 1ns/1ps
module cthi_can_node
    import cthi_pkg::*;
(
    // clock
    input wire logic mclk,
    // toward the history block
    output cthi_tx_evt_t tx_evt,
    output logic can_rx
);
    initial begin
        tx_evt = '0;
        can_rx = 1'b1;
    end

    // one finished transmission, valid for exactly one cycle
    task automatic send(input logic ok, input logic from_fifo, input logic [1:0] idx,
                        input logic store_en, input logic [`CTHI_LABEL_W-1:0] label);
        @(posedge mclk);
        tx_evt <= '{valid: 1'b1, ok: ok, from_fifo: from_fifo, buf_idx: idx, store_en: store_en, label: label};
        @(posedge mclk);
        // released fields turn to junk so a late sampler cannot reuse them
        tx_evt <= '{valid: 1'b0, ok: ~ok, from_fifo: ~from_fifo, buf_idx: ~idx, store_en: ~store_en,
                    label: ~label};
    endtask

    // dominant level on an otherwise recessive bus
    task automatic dominant(input int bits);
        @(posedge mclk);
        can_rx <= 1'b0;
        repeat (bits) @(posedge mclk);
        can_rx <= 1'b1;
    endtask
endmodule

// [can_tx_history_and_irq_tb.sv]
// can_tx_history_and_irq_tb: self-checking bench for cthi_top.
// assumes cthi_pkg and the partner model cthi_can_node are compiled first.
`timescale 1ns/1ps
module can_tx_history_and_irq_tb
    import cthi_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    cthi_bus_req_t bus_req = '0;
    logic [31:0] bus_rdata;
    cthi_tx_evt_t tx_evt;
    logic can_rx;
    logic tx_complete_req, tx_abort_req, fifo_tx_req, dlc_error_req, fifo_msg_lost_req, chan_error_req;
    logic [1:0] rx_fifo_req;
    logic [0:0] txrx_fifo_rx_req;
    logic [8:0] src = '0;
    logic irq_global_rx_fifo, irq_global_error, irq_chan_tx, irq_chan_fifo_rx, irq_chan_error, irq_chan_wakeup;
    logic [5:0] irqs;
    logic [31:0] rd_val;
    int failures = 0;
    int num_checks = 0;

    assign {chan_error_req, fifo_msg_lost_req, dlc_error_req, txrx_fifo_rx_req, rx_fifo_req, fifo_tx_req,
            tx_abort_req, tx_complete_req} = src;
    assign irqs = {irq_global_rx_fifo, irq_global_error, irq_chan_tx, irq_chan_fifo_rx, irq_chan_error,
                   irq_chan_wakeup};

    always #50 mclk = ~mclk;

    cthi_top dut_u (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata), .tx_evt(tx_evt),
        .tx_complete_req(tx_complete_req), .tx_abort_req(tx_abort_req), .fifo_tx_req(fifo_tx_req),
        .rx_fifo_req(rx_fifo_req), .txrx_fifo_rx_req(txrx_fifo_rx_req), .dlc_error_req(dlc_error_req),
        .fifo_msg_lost_req(fifo_msg_lost_req), .chan_error_req(chan_error_req), .can_rx(can_rx),
        .irq_global_rx_fifo(irq_global_rx_fifo), .irq_global_error(irq_global_error),
        .irq_chan_tx(irq_chan_tx), .irq_chan_fifo_rx(irq_chan_fifo_rx), .irq_chan_error(irq_chan_error),
        .irq_chan_wakeup(irq_chan_wakeup));

    cthi_can_node node_u (.mclk(mclk), .tx_evt(tx_evt), .can_rx(can_rx));

    task automatic end_sim();
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge mclk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge mclk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        chk32(bus_rdata, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic t_reset();
        settle();
        chk32({26'h0, irqs}, 32'h0);
        rd_chk(8'h08, 32'h0000_0001);
        rd_chk(8'h14, 32'h0);
    endtask

    task automatic t_store();
        wr(8'h04, 32'h0000_0021);
        node_u.send(1'b1, 1'b0, 2'h3, 1'b1, 8'ha5);
        node_u.send(1'b1, 1'b1, 2'h1, 1'b1, 8'h3c);
        node_u.send(1'b0, 1'b0, 2'h1, 1'b1, 8'h77);
        node_u.send(1'b1, 1'b0, 2'h2, 1'b0, 8'h88);
        rd_chk(8'h08, 32'h0000_0200);
        rd_chk(8'h0c, 32'h0000_a50d);
        wr(8'h0c, 32'h0);
        rd_chk(8'h0c, 32'h0000_3c0a);
        wr(8'h0c, 32'h0);
        rd_chk(8'h08, 32'h0000_0001);
        wr(8'h04, 32'h0);
    endtask

    task automatic t_threshold();
        wr(8'h04, 32'h0000_0005);
        for (int i = 0; i < 5; i++)
            node_u.send(1'b1, 1'b0, 2'(i), 1'b1, 8'(i));
        rd_chk(8'h08, 32'h0000_0500);
        chk1(irq_chan_tx, 1'b0);
        node_u.send(1'b1, 1'b0, 2'h1, 1'b1, 8'h55);
        rd_chk(8'h08, 32'h0000_0608);
        settle();
        chk1(irq_chan_tx, 1'b1);
        rd_chk(8'h10, 32'h0000_0008);
        wr(8'h04, 32'h0);
        rd_chk(8'h08, 32'h0000_0009);
        settle();
        chk1(irq_chan_tx, 1'b0);
        // service leaves only after every request flag reads back clear
        wr(8'h08, 32'h0);
        rd_chk(8'h08, 32'h0000_0001);
        rd_chk(8'h10, 32'h0);
    endtask

    task automatic t_every();
        wr(8'h04, 32'h0000_0003);
        node_u.send(1'b1, 1'b1, 2'h0, 1'b1, 8'h11);
        rd_chk(8'h08, 32'h0000_0108);
        settle();
        chk1(irq_chan_tx, 1'b0);
        wr(8'h08, 32'h0);
        rd_chk(8'h08, 32'h0000_0100);
        node_u.send(1'b1, 1'b0, 2'h2, 1'b1, 8'h22);
        rd_chk(8'h08, 32'h0000_0208);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h0);
    endtask

    task automatic t_overflow();
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0000_0001);
        for (int i = 0; i < 9; i++)
            node_u.send(1'b1, 1'b0, 2'(i), 1'b1, 8'(i));
        rd_chk(8'h08, 32'h0000_080e);
        settle();
        chk1(irq_global_error, 1'b0);
        wr(8'h00, 32'h0000_0001);
        settle();
        chk1(irq_global_error, 1'b1);
        rd_chk(8'h0c, 32'h0000_0001);
        wr(8'h08, 32'h0);
        settle();
        chk1(irq_global_error, 1'b0);
        // overflow with reporting already on, then a pop and a store in one cycle
        node_u.send(1'b1, 1'b1, 2'h0, 1'b1, 8'h99);
        settle();
        chk1(irq_global_error, 1'b1);
        rd_chk(8'h08, 32'h0000_0806);
        wr(8'h08, 32'h0);
        fork
            wr(8'h0c, 32'h0);
            node_u.send(1'b1, 1'b0, 2'h2, 1'b1, 8'h42);
        join
        rd_chk(8'h08, 32'h0000_0802);
        rd_chk(8'h0c, 32'h0000_0105);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
    endtask

    // one source at a time, expected outputs as {grx, gerr, tx, frx, cerr, wake}
    task automatic t_irqs();
        logic [5:0] tbl [9];
        tbl = '{6'h08, 6'h08, 6'h08, 6'h20, 6'h20, 6'h04, 6'h10, 6'h10, 6'h02};
        for (int i = 0; i < 9; i++) begin
            @(posedge mclk);
            src <= 9'(1 << i);
            settle();
            chk32({26'h0, irqs}, {26'h0, tbl[i]});
            if (i < 3)
                rd_chk(8'h10, 32'(1 << i));
            @(posedge mclk);
            src <= '0;
        end
        settle();
        chk32({26'h0, irqs}, 32'h0);
    endtask

    task automatic t_wake();
        int n;
        n = 0;
        fork
            node_u.dominant(3);
            repeat (8) begin
                @(posedge mclk);
                #1;
                n += int'(irq_chan_wakeup);
            end
        join
        chk32(32'(n), 32'h1);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_store();
        t_threshold();
        t_every();
        t_overflow();
        t_irqs();
        t_wake();
        end_sim();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        end_sim();
    end
endmodule
